// ===== rtl/sams_seq.sv
// serial interface and conversion sequencer of the converter
`timescale 1ns/1ps
`default_nettype none
// How it works
// - conversion begins on select low; select stays low for whole sequence
// - before start bit, serial input sampled on each rising serial clock edge
// - first sampled one is the start bit; leading zeros ignored
// - two-channel variant captures two assignment bits after the start bit
// - first bit one means single-ended; second bit picks channel 0 or 1
// - differential: second bit zero makes ch0 positive, one reverses
// - single-channel variant takes no assignment bits, converts after start
// - result is positive minus negative, zero when positive is lower
// - half clock settling interval; serial input ignored afterwards
// - output leaves high impedance at settling, drives one leading zero
// - each comparison bit driven on falling edge, MSB first
// - conversion complete after eight clock periods, one bit each
// - two-channel variant then repeats result bits 1 to 7 LSB first; bit 0 is sent once
// - after last data bit, output held low until select returns high
// - single-channel variant sends only the MSB-first result
// - input looked at only while output is high impedance; lines joinable
// - select high: logic static, serial output high impedance
module sams_seq
    import sams_pkg::*;
#(
    parameter int WIDTH = SAMS_RESULT_BITS
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial pins
    input wire logic cs_n_pin,
    input wire logic sclk_pin,
    input wire logic serial_in_pin,
    output logic serial_out_o,
    output logic serial_out_oe_n,
    // analog front end
    input wire logic comp_above,
    output logic [WIDTH-1:0] dac_code,
    output sams_pkg::sams_mux_t mux_sel,
    output logic sample_hold
);
    localparam int IW = $clog2(WIDTH);

    // ----------------------------------------------------------------
    // pin synchronisation
    // ----------------------------------------------------------------
    sams_pins_t pins;
    logic sclk_rise;
    logic sclk_fall;

    sams_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .cs_n_pin(cs_n_pin),
        .sclk_pin(sclk_pin),
        .serial_in_pin(serial_in_pin),
        .pins(pins),
        .sclk_rise(sclk_rise),
        .sclk_fall(sclk_fall)
    );

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    sams_state_t state_reg;
    logic two_ch_reg;
    logic [1:0] addr_reg;
    logic [1:0] addr_cnt_reg;
    logic [IW-1:0] bit_cnt_reg;
    logic [WIDTH-1:0] shift_reg;
    logic [WIDTH-1:0] last_result_reg;
    logic done_reg;
    logic step_pend_reg;
    logic [WIDTH-1:0] trial;
    logic [WIDTH-1:0] approx_result_reg;
    logic approx_clear;
    logic approx_step;
    logic deselect;

    assign deselect = pins.cs_n;

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    // channel assignment decode
    function automatic sams_mux_t mux_decode(input logic two_ch, input logic [1:0] addr);
        sams_mux_t m;
        if (!two_ch) begin
            m = '{mode_single_diff: 1'b0, odd_sign: 1'b0, pos_ch1: 1'b0,
                  neg_used: 1'b1, neg_ch1: 1'b1};
        end else begin
            m.mode_single_diff = addr[1];
            m.odd_sign = addr[0];
            m.pos_ch1 = addr[0];
            m.neg_used = ~addr[1];
            m.neg_ch1 = ~addr[0];
        end
        return m;
    endfunction

    // waiting for start, addressing or settling: the assignment is still being formed
    function automatic logic mux_open(input sams_state_t s);
        return (s == SAMS_WAIT_START) || (s == SAMS_ADDR) || (s == SAMS_SETTLE);
    endfunction

    // ----------------------------------------------------------------
    // approximation register
    // ----------------------------------------------------------------
    // clamp by comparison
    assign approx_clear = (state_reg == SAMS_SETTLE) && sclk_fall;
    assign approx_step = step_pend_reg;

    sams_approx #(
        .WIDTH(WIDTH)
    ) u_approx (
        .pclk(pclk),
        .presetn(presetn),
        .clear(approx_clear),
        .step(approx_step),
        .bit_idx(bit_cnt_reg),
        .comp_above(comp_above),
        .trial(trial),
        .approx_result_reg(approx_result_reg)
    );

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= SAMS_IDLE;
            addr_reg <= 2'b00;
            addr_cnt_reg <= 2'b00;
            bit_cnt_reg <= '0;
            shift_reg <= '0;
            step_pend_reg <= 1'b0;
        end else if (deselect) begin
            state_reg <= SAMS_IDLE;
            step_pend_reg <= 1'b0;
        end else begin
            step_pend_reg <= 1'b0;
            case (state_reg)
                SAMS_IDLE: begin
                    state_reg <= SAMS_WAIT_START;
                end
                SAMS_WAIT_START: begin
                    if (sclk_rise && pins.serial_in) begin
                        addr_cnt_reg <= 2'b00;
                        state_reg <= two_ch_reg ? SAMS_ADDR : SAMS_SETTLE;
                    end
                end
                SAMS_ADDR: begin
                    if (sclk_rise) begin
                        addr_reg <= {addr_reg[0], pins.serial_in};
                        addr_cnt_reg <= addr_cnt_reg + 2'd1;
                        if (addr_cnt_reg == 2'(SAMS_ADDR_BITS - 1)) begin
                            state_reg <= SAMS_SETTLE;
                        end
                    end
                end
                SAMS_SETTLE: begin
                    if (sclk_fall) begin
                        bit_cnt_reg <= IW'(WIDTH - 1);
                        state_reg <= SAMS_MSB;
                    end
                end
                SAMS_MSB: begin
                    if (sclk_fall) begin
                        step_pend_reg <= 1'b1;
                    end
                    if (step_pend_reg) begin
                        if (bit_cnt_reg == '0) begin
                            state_reg <= two_ch_reg ? SAMS_LSB : SAMS_TAIL;
                            bit_cnt_reg <= IW'(1);
                            shift_reg <= {1'b0, approx_result_reg[WIDTH-1:1]};
                        end else begin
                            bit_cnt_reg <= bit_cnt_reg - IW'(1);
                        end
                    end
                end
                SAMS_LSB: begin
                    if (sclk_fall) begin
                        shift_reg <= shift_reg >> 1;
                        if (bit_cnt_reg == IW'(WIDTH - 1)) begin
                            state_reg <= SAMS_TAIL;
                        end else begin
                            bit_cnt_reg <= bit_cnt_reg + IW'(1);
                        end
                    end
                end
                SAMS_TAIL: begin
                    state_reg <= SAMS_TAIL;
                end
                default: begin
                    state_reg <= SAMS_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // serial output pin
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_out_o <= 1'b0;
            serial_out_oe_n <= 1'b1;
        end else if (deselect) begin
            serial_out_o <= 1'b0;
            serial_out_oe_n <= 1'b1;
        end else begin
            case (state_reg)
                SAMS_WAIT_START, SAMS_ADDR: begin
                    serial_out_o <= 1'b0;
                    serial_out_oe_n <= 1'b1;
                    if (sclk_fall) begin
                        serial_out_oe_n <= 1'b1;
                    end
                end
                SAMS_SETTLE: begin
                    serial_out_o <= 1'b0;
                    serial_out_oe_n <= 1'b0;
                end
                SAMS_MSB: begin
                    if (step_pend_reg) begin
                        serial_out_o <= comp_above;
                    end
                end
                SAMS_LSB: begin
                    if (sclk_fall) begin
                        serial_out_o <= shift_reg[0];
                    end
                end
                SAMS_TAIL: begin
                    if (sclk_fall) begin
                        serial_out_o <= 1'b0;
                    end
                end
                default: begin
                    serial_out_o <= 1'b0;
                    serial_out_oe_n <= 1'b1;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // front end drive
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_code <= '0;
            mux_sel <= '0;
            sample_hold <= 1'b0;
        end else begin
            dac_code <= trial;
            sample_hold <= (state_reg == SAMS_SETTLE);
            if (mux_open(state_reg)) begin
                mux_sel <= mux_decode(two_ch_reg, addr_reg);
            end
        end
    end

    // ----------------------------------------------------------------
    // result capture
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_result_reg <= '0;
            done_reg <= 1'b0;
        end else if (state_reg == SAMS_MSB && step_pend_reg && bit_cnt_reg == '0) begin
            last_result_reg <= {approx_result_reg[WIDTH-1:1], comp_above};
            done_reg <= 1'b1;
        end else if (psel && penable && !pwrite && paddr == SAMS_OFF_RESULT) begin
            done_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // apb registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            two_ch_reg <= SAMS_CTRL_RESET[SAMS_CTRL_TWO_CH_BIT];
        end else if (psel && penable && pwrite && paddr == SAMS_OFF_CTRL && pstrb[0]) begin
            two_ch_reg <= pwdata[SAMS_CTRL_TWO_CH_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel && !penable) begin
                case (paddr)
                    SAMS_OFF_CTRL: prdata <= {31'd0, two_ch_reg};
                    SAMS_OFF_STATUS: prdata <= {25'd0, state_reg, 2'b00, done_reg,
                                                state_reg != SAMS_IDLE};
                    SAMS_OFF_RESULT: prdata <= {24'd0, last_result_reg};
                    SAMS_OFF_CONFIG: prdata <= {27'd0, mux_sel};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end
endmodule // sams_seq
`default_nettype wire

// ===== include/sams_pkg.sv
// package of constants and carrier types for the serial converter sequencer
package sams_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [11:0] SAMS_OFF_CTRL = 12'h000;
    localparam logic [11:0] SAMS_OFF_STATUS = 12'h004;
    localparam logic [11:0] SAMS_OFF_RESULT = 12'h008;
    localparam logic [11:0] SAMS_OFF_CONFIG = 12'h00c;

    // ctrl fields
    localparam int SAMS_CTRL_TWO_CH_BIT = 0;
    localparam logic [31:0] SAMS_CTRL_RESET = 32'h0000_0001;

    // status fields
    localparam int SAMS_ST_BUSY_BIT = 0;
    localparam int SAMS_ST_DONE_BIT = 1;
    localparam int SAMS_ST_STATE_LSB = 4;

    // ----------------------------------------------------------------
    // serial timing
    // ----------------------------------------------------------------
    localparam int SAMS_PCLK_MHZ = 100;
    localparam int SAMS_SCLK_MAX_MHZ = 2;
    localparam int SAMS_SCLK_MIN_CYC = SAMS_PCLK_MHZ / SAMS_SCLK_MAX_MHZ;
    localparam int SAMS_RESULT_BITS = 8;
    localparam int SAMS_ADDR_BITS = 2;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SAMS_IDLE = 3'b000,
        SAMS_WAIT_START = 3'b001,
        SAMS_ADDR = 3'b010,
        SAMS_SETTLE = 3'b011,
        SAMS_MSB = 3'b100,
        SAMS_LSB = 3'b101,
        SAMS_TAIL = 3'b110
    } sams_state_t;

    // multiplexer selection toward the analog front end
    typedef struct packed {
        logic mode_single_diff;
        logic odd_sign;
        logic pos_ch1;
        logic neg_used;
        logic neg_ch1;
    } sams_mux_t;

    // serial pins after synchronisation
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic serial_in;
    } sams_pins_t;

endpackage : sams_pkg

// ===== rtl/sams_sync.sv
// two flop synchroniser with edge detection after the second stage
`timescale 1ns/1ps
`default_nettype none
module sams_sync
    import sams_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // raw pins
    input wire logic cs_n_pin,
    input wire logic sclk_pin,
    input wire logic serial_in_pin,
    // synchronised
    output sams_pkg::sams_pins_t pins,
    output logic sclk_rise,
    output logic sclk_fall
);
    logic [2:0] meta_reg;
    sams_pins_t stage_reg;
    logic sclk_d_reg;

    // ----------------------------------------------------------------
    // two stages
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= 3'b100;
            stage_reg <= '{cs_n: 1'b1, sclk: 1'b0, serial_in: 1'b0};
            sclk_d_reg <= 1'b0;
        end else begin
            meta_reg <= {cs_n_pin, sclk_pin, serial_in_pin};
            stage_reg <= meta_reg;
            sclk_d_reg <= stage_reg.sclk;
        end
    end

    assign pins = stage_reg;
    assign sclk_rise = stage_reg.sclk & ~sclk_d_reg;
    assign sclk_fall = ~stage_reg.sclk & sclk_d_reg;
endmodule // sams_sync
`default_nettype wire

// ===== rtl/sams_approx.sv
// successive approximation step logic against the front end comparator
`timescale 1ns/1ps
`default_nettype none
module sams_approx
    import sams_pkg::*;
#(
    parameter int WIDTH = SAMS_RESULT_BITS
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic clear,
    input wire logic step,
    input wire logic [$clog2(WIDTH)-1:0] bit_idx,
    // comparator: positive input above trial level
    input wire logic comp_above,
    // outputs
    output logic [WIDTH-1:0] trial,
    output logic [WIDTH-1:0] approx_result_reg
);
    // ----------------------------------------------------------------
    // trial code: result so far with the current bit set
    // ----------------------------------------------------------------
    always_comb begin
        trial = approx_result_reg;
        trial[bit_idx] = 1'b1;
    end

    // ----------------------------------------------------------------
    // keep bit when comparator high; negative difference ends at zero
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            approx_result_reg <= '0;
        end else if (clear) begin
            approx_result_reg <= '0;
        end else if (step) begin
            approx_result_reg[bit_idx] <= comp_above;
        end
    end
endmodule // sams_approx
`default_nettype wire

// ===== tb/sams_seq_sva.sv
// assertion checker on the ports of the serial converter sequencer
`timescale 1ns/1ps
`default_nettype none
module sams_seq_sva
    import sams_pkg::*;
#(
    parameter int WIDTH = SAMS_RESULT_BITS
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // serial pins and front end
    input wire logic cs_n_pin,
    input wire logic sclk_pin,
    input wire logic serial_out_o,
    input wire logic serial_out_oe_n,
    input wire logic [WIDTH-1:0] dac_code,
    input wire sams_pkg::sams_mux_t mux_sel,
    input wire logic sample_hold
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // --------------------
    // apb answers
    // --------------------
    chk_setup_ready: assert property (psel && !penable |=> pready)
        else $error("pready missing in access cycle");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_refused_zero: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0000_0000)
        else $error("refused read not zero");
    // --------------------
    // serial side and front end
    // --------------------
    chk_idle_hiz: assert property (cs_n_pin [*6] |-> serial_out_oe_n)
        else $error("output driven while deselected");
    chk_abort_hiz: assert property ($rose(cs_n_pin) |-> ##[1:6] serial_out_oe_n)
        else $error("output not released after select high");
    chk_lead_zero: assert property ($fell(serial_out_oe_n) |-> !serial_out_o)
        else $error("first driven bit not zero");
    chk_hold_settle: assert property ($fell(serial_out_oe_n) |-> sample_hold)
        else $error("hold not raised in settling interval");
    chk_out_on_fall: assert property (!serial_out_oe_n && !$past(serial_out_oe_n)
        && sclk_pin && $past(sclk_pin, 6) |-> $stable(serial_out_o))
        else $error("output changed while serial clock high");
    chk_front_static: assert property (cs_n_pin [*6] |=> $stable(dac_code)
        && $stable(mux_sel))
        else $error("front end changed while deselected");
    cover property ($fell(serial_out_oe_n));
    cover property (pslverr);
    cover property ($rose(cs_n_pin) && !serial_out_oe_n);
endmodule // sams_seq_sva

bind sams_seq sams_seq_sva #(.WIDTH(WIDTH)) u_sva (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .cs_n_pin(cs_n_pin),
    .sclk_pin(sclk_pin),
    .serial_out_o(serial_out_o),
    .serial_out_oe_n(serial_out_oe_n),
    .dac_code(dac_code),
    .mux_sel(mux_sel),
    .sample_hold(sample_hold)
);
`default_nettype wire

// ===== tb/sams_host.sv
// host model driving select, serial clock and data, capturing output
`timescale 1ns/1ps
`default_nettype none
module sams_host
(
    // clock
    input wire logic pclk,
    // serial lines
    output logic cs_n_pin,
    output logic sclk_pin,
    output logic serial_in_pin,
    input wire logic serial_out_o,
    input wire logic serial_out_oe_n
);
    localparam int HALF = 25;
    logic cs_q = 1'b1;
    logic sclk_q = 1'b0;
    logic drive_q = 1'b0;
    logic din_q = 1'b0;
    logic junk_q = 1'b0;
    assign cs_n_pin = cs_q;
    assign sclk_pin = sclk_q;
    assign serial_in_pin = drive_q ? din_q : junk_q;
    always @(posedge pclk) begin
        junk_q <= ~junk_q;
    end
    task automatic wait_n(input int n);
        repeat (n) @(posedge pclk);
    endtask
    function automatic logic rx();
        return serial_out_oe_n ? 1'bz : serial_out_o;
    endfunction
    // select held, bits sent, bits taken
    task automatic frame(input int nin, input logic [7:0] din, input int nrx,
                         output logic [16:0] dout);
        dout = '0;
        @(posedge pclk);
        cs_q <= 1'b0;
        drive_q <= 1'b1;
        for (int i = nin - 1; i >= 0; i--) begin
            din_q <= din[i];
            wait_n(HALF);
            sclk_q <= 1'b1;
            wait_n(HALF);
            if (i == 0) begin
                drive_q <= 1'b0;
            end
            sclk_q <= 1'b0;
        end
        for (int i = 0; i < nrx; i++) begin
            wait_n(HALF);
            dout = {dout[15:0], rx()};
            sclk_q <= 1'b1;
            wait_n(HALF);
            sclk_q <= 1'b0;
        end
        wait_n(HALF);
        cs_q <= 1'b1;
    endtask
endmodule // sams_host
`default_nettype wire

// ===== tb/sams_seq_test.sv
// self-checking bench for the serial converter sequencer
`timescale 1ns/1ps
`default_nettype none
module sams_seq_test;
    import sams_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready, pslverr, serial_out_o, serial_out_oe_n, sample_hold, comp_above;
    wire logic cs_n_pin, sclk_pin, serial_in_pin;
    logic [7:0] dac_code;
    sams_mux_t mux_sel;
    real ch0 = 100.5;
    real ch1 = 37.25;
    real pos_v, neg_v, d;
    int error_cnt = 0;
    int total_checks = 0;
    logic [31:0] rd;
    logic err;
    logic [16:0] got;
    always #5 pclk = ~pclk;
    // --------------------
    // front end comparator and units
    // --------------------
    always_comb begin
        pos_v = mux_sel.pos_ch1 ? ch1 : ch0;
        neg_v = !mux_sel.neg_used ? 0.0 : (mux_sel.neg_ch1 ? ch1 : ch0);
        comp_above = (pos_v - neg_v) > real'(dac_code);
    end
    sams_seq #(.WIDTH(8)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .serial_in_pin(serial_in_pin),
        .serial_out_o(serial_out_o), .serial_out_oe_n(serial_out_oe_n),
        .comp_above(comp_above), .dac_code(dac_code), .mux_sel(mux_sel),
        .sample_hold(sample_hold)
    );
    sams_host host (
        .pclk(pclk), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
        .serial_in_pin(serial_in_pin), .serial_out_o(serial_out_o),
        .serial_out_oe_n(serial_out_oe_n)
    );
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= dat;
        pstrb <= 4'hf;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) begin
            chk("pready", 32'h1, 32'h0);
            test_done();
        end
    endtask
    function automatic logic [7:0] conv(input real x);
        return (x < 0.0) ? 8'h00 : 8'($rtoi(x));
    endfunction
    function automatic logic [16:0] exp_bits(input logic [7:0] r, input bit two);
        if (two) begin
            return {1'b0, r, r[1], r[2], r[3], r[4], r[5], r[6], r[7], 1'b0};
        end
        return {8'h00, r, 1'b0};
    endfunction
    task automatic hiz_chk();
        repeat (8) @(posedge pclk);
        chk("oe_n", 32'h1, {31'h0, serial_out_oe_n});
    endtask
    // --------------------
    // sequence
    // --------------------
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(SAMS_OFF_CTRL, 1'b0, 32'h0);
        chk("ctrl", SAMS_CTRL_RESET, rd);
        apb(12'h010, 1'b1, 32'hffff_ffff);
        chk("err", 32'h1, {31'h0, err});
        apb(12'h010, 1'b0, 32'h0);
        chk("bad rd", 32'h0, rd);
        for (int k = 0; k < 4; k++) begin
            host.frame(3 + k, 8'(4 + k), 17, got);
            d = k[1] ? (k[0] ? ch1 : ch0) : (k[0] ? ch1 - ch0 : ch0 - ch1);
            chk("frame", {15'h0, exp_bits(conv(d), 1'b1)}, {15'h0, got});
            hiz_chk();
            apb(SAMS_OFF_STATUS, 1'b0, 32'h0);
            chk("status done", 32'h0000_0002, rd);
            apb(SAMS_OFF_RESULT, 1'b0, 32'h0);
            chk("result", {24'h0, conv(d)}, {24'h0, rd[7:0]});
        end
        apb(SAMS_OFF_STATUS, 1'b0, 32'h0);
        chk("status clear", 32'h0000_0000, rd);
        host.frame(3, 8'h06, 5, got);
        chk("abort", {15'h0, exp_bits(8'h64, 1'b1) >> 12}, {15'h0, got});
        hiz_chk();
        host.frame(3, 8'h07, 17, got);
        chk("after", {15'h0, exp_bits(conv(ch1), 1'b1)}, {15'h0, got});
        apb(SAMS_OFF_CTRL, 1'b1, 32'h0);
        host.frame(3, 8'h01, 10, got);
        chk("single", {15'h0, exp_bits(conv(ch0 - ch1), 1'b0)}, {15'h0, got});
        hiz_chk();
        test_done();
    end
    initial begin
        repeat (50000) @(posedge pclk);
        chk("watchdog", 32'h0, 32'h1);
        test_done();
    end
endmodule // sams_seq_test
`default_nettype wire
